// [hdl/sadc_consts.svh]
// Timing counts and frame positions for the serial converter readout
`ifndef SADC_CONSTS_SVH
`define SADC_CONSTS_SVH

`define SADC_CNT_W       5
`define SADC_FIRST_BIT   5'h03
`define SADC_FRAME_SLOTS 5'h10
`define SADC_DONE_CNT    5'h11
`define SADC_RES_DEFAULT 14
`define SADC_FIFO_DEPTH  32

`endif

// [hdl/sadc_pkg.sv]
// Types shared by the serial converter readout
package sadc_pkg;

  // Where the frame stands after a given count of serial clock rises
  typedef enum logic [1:0] {
    PH_LEAD = 2'b00,
    PH_DATA = 2'b01,
    PH_PAD  = 2'b10,
    PH_IDLE = 2'b11
  } sadc_phase_t;

endpackage

// [hdl/sadc_readout.sv]
// Result FIFO and serial output frame logic of the sampling converter
`timescale 1ns/1ps
`default_nettype none
`include "sadc_consts.svh"

////////////////////////////////////////////////////////////////////////////////
// Result FIFO: registered input ready, first word shown on the output side
module sadc_fifo #(
  parameter int W     = `SADC_RES_DEFAULT,
  parameter int DEPTH = `SADC_FIFO_DEPTH
) (
  input  wire logic         clk,
  input  wire logic         rstN,
  input  wire logic [W-1:0] inData,
  input  wire logic         inValid,
  output var  logic         inReady,
  output var  logic [W-1:0] outData,
  output var  logic         outValid,
  input  wire logic         outReady
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = DEPTH[AW:0];

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_r;
  logic [AW-1:0] rdPtr_r;
  logic [AW:0]   count_r;
  logic [AW:0]   count_nxt;
  logic          push;
  logic          pop;

  // Handshakes on both sides
  assign push     = inValid && inReady;
  assign pop      = outReady && outValid;
  assign outValid = (count_r != '0);
  assign outData  = mem[rdPtr_r];

  // Fill level after this cycle
  always_comb begin
    count_nxt = count_r;
    if (push && !pop) begin
      count_nxt = count_r + 1'b1;
    end else if (pop && !push) begin
      count_nxt = count_r - 1'b1;
    end
  end

  // Storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_r] <= inData;
    end
  end

  // Pointers, level and ready
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
      inReady <= 1'b0;
    end else begin
      if (push) begin
        wrPtr_r <= wrPtr_r + 1'b1;
      end
      if (pop) begin
        rdPtr_r <= rdPtr_r + 1'b1;
      end
      count_r <= count_nxt;
      inReady <= (count_nxt != FULL_CNT); // Back-pressure to the converter core
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module sadc_readout #(
  parameter int RES   = `SADC_RES_DEFAULT,
  parameter int DEPTH = `SADC_FIFO_DEPTH
) (
  input  wire logic           core_clk,
  input  wire logic           rst_n,
  input  wire logic           serialClk,
  input  wire logic           conversion_start_in,
  input  wire logic [RES-1:0] sampleData,
  input  wire logic           sampleValid,
  output var  logic           sampleReady,
  output var  logic           sdoOut,
  output var  logic           sdoOeN,
  output var  logic           napMode
);
  localparam logic [`SADC_CNT_W-1:0] LAST_BIT = 5'(RES + 2);

  logic                   rstMeta_r;
  logic                   rstSyncN;
  logic                   sckPrev_r;
  logic                   convPrev_r;
  logic                   sckRise;
  logic                   convRise;
  logic                   convAccept;
  logic                   convArmed_r;
  logic [`SADC_CNT_W-1:0] cnt_r;
  logic [`SADC_CNT_W-1:0] cnt_nxt;
  logic [RES-1:0]         shift_r;
  logic [RES-1:0]         fifoData;
  logic                   fifoValid;
  sadc_pkg::sadc_phase_t  phaseNxt;

  // Frame phase reached after a given number of serial clock rises
  function automatic sadc_pkg::sadc_phase_t phaseOf(input logic [`SADC_CNT_W-1:0] c);
    if (c < `SADC_FIRST_BIT) begin
      phaseOf = sadc_pkg::PH_LEAD;
    end else if (c <= LAST_BIT) begin
      phaseOf = sadc_pkg::PH_DATA;
    end else if (c <= `SADC_FRAME_SLOTS) begin
      phaseOf = sadc_pkg::PH_PAD;
    end else begin
      phaseOf = sadc_pkg::PH_IDLE;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Reset release through two flip-flops
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_r <= 1'b0;
      rstSyncN  <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSyncN  <= rstMeta_r;
    end
  end

  // Edge detection of the host-driven pins
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      sckPrev_r  <= 1'b0;
      convPrev_r <= 1'b0;
    end else begin
      sckPrev_r  <= serialClk;
      convPrev_r <= conversion_start_in;
    end
  end

  assign sckRise    = serialClk && !sckPrev_r;
  assign convRise   = conversion_start_in && !convPrev_r;
  assign convAccept = convRise && (cnt_r >= `SADC_FRAME_SLOTS);

  //////////////////////////////////////////////////////////////////////////////
  // Result buffer between converter core and shifter
  sadc_fifo #(
    .W     (RES),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk      (core_clk),
    .rstN     (rstSyncN),
    .inData   (sampleData),
    .inValid  (sampleValid),
    .inReady  (sampleReady),
    .outData  (fifoData),
    .outValid (fifoValid),
    .outReady (convAccept)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Rise count within the frame, saturating once the frame is over
  always_comb begin
    cnt_nxt = cnt_r;
    if (convAccept) begin
      cnt_nxt = {4'h0, sckRise};
    end else if (sckRise && cnt_r != `SADC_DONE_CNT) begin
      cnt_nxt = cnt_r + 5'h01;
    end
  end

  assign phaseNxt = phaseOf(cnt_nxt);

  // Frame counter; reset leaves the device idle and ready
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      cnt_r <= `SADC_DONE_CNT;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Result shifter, loaded from the buffer at conversion start
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      shift_r <= '0;
    end else if (convAccept) begin
      shift_r <= fifoValid ? fifoData : '0;
    end else if (sckRise && phaseNxt == sadc_pkg::PH_DATA) begin
      shift_r <= {shift_r[RES-2:0], 1'b0};
    end
  end

  // Data line: updated on rises and released at an accepted start, high impedance outside the result and pad slots
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      sdoOut <= 1'b0;
      sdoOeN <= 1'b1;
    end else if (sckRise) begin
      case (phaseNxt)
        sadc_pkg::PH_DATA: begin
          sdoOut <= shift_r[RES-1];
          sdoOeN <= 1'b0;
        end
        sadc_pkg::PH_PAD: begin
          sdoOut <= 1'b0;
          sdoOeN <= 1'b0;
        end
        default: begin
          sdoOut <= 1'b0;
          sdoOeN <= 1'b1;
        end
      endcase
    end else if (convAccept) begin
      sdoOut <= 1'b0;
      sdoOeN <= 1'b1;
    end
  end

  // Nap detection: a second start rise with no clock rise in between
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      convArmed_r <= 1'b0;
      napMode     <= 1'b0;
    end else if (sckRise) begin
      convArmed_r <= 1'b0;
      napMode     <= 1'b0;
    end else if (convRise) begin
      convArmed_r <= 1'b1;
      if (convArmed_r) begin
        napMode <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstSyncN);

  a_count_step: assert property (
    (sckRise && !convAccept && cnt_r != `SADC_DONE_CNT) |=> cnt_r == $past(cnt_r) + 5'h01
  ) else $error("serial clock rise did not advance frame count");

  a_first_bit_third: assert property (
    (sckRise && !convAccept && cnt_r == 5'h02) |=> !sdoOeN && sdoOut == $past(shift_r[RES-1])
  ) else $error("MSB not presented at third serial clock rise");

  a_powerup_hiz: assert property (
    @(posedge core_clk) disable iff (!rst_n) $rose(rstSyncN) |-> sdoOeN && !napMode
  ) else $error("data line driven or nap set after power-up");

  a_idle_hiz: assert property (
    (cnt_r == `SADC_DONE_CNT) |-> sdoOeN
  ) else $error("data line driven outside a frame");

  a_lead_hiz: assert property (
    (phaseOf(cnt_r) == sadc_pkg::PH_LEAD) |-> sdoOeN
  ) else $error("data line driven before first result bit");

  a_stable_between: assert property (
    (!sckRise && !convAccept) |=> $stable(sdoOut) && $stable(sdoOeN)
  ) else $error("data line changed without serial clock rise");

  a_busy_ignores: assert property (
    (convRise && cnt_r < `SADC_FRAME_SLOTS && !sckRise) |=> cnt_r == $past(cnt_r)
  ) else $error("conversion start accepted during busy frame");

  a_nap_entry: assert property (
    (convRise && convArmed_r && !sckRise) |=> napMode
  ) else $error("nap not entered on second start rise");

  a_nap_wake: assert property (
    (napMode && sckRise) |=> !napMode
  ) else $error("nap not left on serial clock rise");

  a_last_slot: assert property (
    (cnt_r == `SADC_FRAME_SLOTS) |-> !sdoOeN && (RES == 14 || !sdoOut)
  ) else $error("sixteenth slot not driven as expected");
endmodule
`default_nettype wire

// [tb/sadc_host_model.sv]
// Host serial port model driving the serial clock and conversion start
`timescale 1ns/1ps
`default_nettype none
module sadc_host_model (
  input  wire logic core_clk,
  input  wire logic sdoOut,
  input  wire logic sdoOeN,
  output var  logic serialClk,
  output var  logic conversion_start_in
);
  logic      lastLine;
  wire logic sdoLine;
  // Released line shows the inverse of its last level
  assign sdoLine = sdoOeN ? ~lastLine : sdoOut;
  // Idle pins at time zero
  initial begin
    serialClk = 1'b0;
    conversion_start_in = 1'b0;
    lastLine = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Start pulse, two cycles high then two low
  task automatic start_pulse();
    conversion_start_in = 1'b1;
    repeat (2) @(posedge core_clk);
    #1 conversion_start_in = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  // One serial clock, bit taken on the falling edge
  task automatic sck_cycle(output logic bitv, output logic oeN);
    serialClk = 1'b1;
    repeat (2) @(posedge core_clk);
    #1 serialClk = 1'b0;
    bitv = sdoLine;
    oeN = sdoOeN;
    lastLine = sdoLine;
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  // Whole frame of n clocks, optional extra start before clock extraAt
  task automatic frame(input int n, input int extraAt, output logic [15:0] word,
                       output logic [16:0] hiz);
    logic b;
    logic z;
    word = '0;
    hiz = '0;
    start_pulse();
    for (int s = 1; s <= n; s++) begin
      if (s == extraAt) start_pulse();
      sck_cycle(b, z);
      if (s <= 16) word = {word[14:0], b};
      if (s <= 17) hiz[s-1] = z;
    end
  endtask
endmodule
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the serial converter readout
`timescale 1ns/1ps
`default_nettype none
`include "sadc_consts.svh"
module testbench;
  localparam int RES = 14;
  logic           core_clk;
  logic           rst_n;
  logic           sampleValid;
  logic [RES-1:0] sampleData;
  wire logic      serialClk;
  wire logic      conversion_start_in;
  wire logic      sampleReady;
  wire logic      sdoOut;
  wire logic      sdoOeN;
  wire logic      napMode;
  int             mismatches;
  int             nTests;
  logic [15:0]    word;
  logic [16:0]    hiz;
  logic           b;
  logic           z;

  sadc_readout #(.RES(RES), .DEPTH(`SADC_FIFO_DEPTH)) i_sadc_readout (
    .core_clk(core_clk), .rst_n(rst_n), .serialClk(serialClk),
    .conversion_start_in(conversion_start_in), .sampleData(sampleData),
    .sampleValid(sampleValid), .sampleReady(sampleReady), .sdoOut(sdoOut),
    .sdoOeN(sdoOeN), .napMode(napMode));
  sadc_host_model i_sadc_host_model (
    .core_clk(core_clk), .sdoOut(sdoOut), .sdoOeN(sdoOeN), .serialClk(serialClk),
    .conversion_start_in(conversion_start_in));

  // Clock generator
  always #10 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////////////
  // Compare and verdict
  task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
    nTests++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    if (mismatches == 0 && nTests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  function automatic logic [RES-1:0] wordOf(input int i);
    return RES'(16'h2A5C + i * 16'h0193);
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // Fill the FIFO until refused while the host stalls
  task automatic fill_fifo();
    int k;
    for (int i = 0; i < `SADC_FIFO_DEPTH; i++) begin
      sampleData = wordOf(i);
      sampleValid = 1'b1;
      k = 0;
      while (sampleReady !== 1'b1 && k < 50) begin
        @(posedge core_clk);
        #1 k++;
      end
      if (k == 50) begin
        mismatches++;
        end_of_test();
      end
      @(posedge core_clk);
      #1;
    end
    sampleData = wordOf(99);
    repeat (3) @(posedge core_clk);
    #1 check("ready when full", sampleReady, 17'h00000);
    sampleValid = 1'b0;
  endtask
  // Drain through frames, with a short frame and an ignored start
  task automatic drain_frames();
    for (int i = 0; i <= `SADC_FIFO_DEPTH; i++) begin
      i_sadc_host_model.frame((i == 5) ? 16 : 17, (i == 9) ? 8 : 0, word, hiz);
      check("word", word[RES-1:0], (i < `SADC_FIFO_DEPTH) ? wordOf(i) : '0);
      check("hiz slots", hiz, (i == 5) ? 17'h00003 : 17'h10003);
      if (i == 0) check("ready after pop", sampleReady, 17'h00001);
    end
  endtask
  // Two starts without a clock enter nap, a clock wakes
  task automatic nap_check();
    i_sadc_host_model.start_pulse();
    check("nap early", napMode, 17'h00000);
    i_sadc_host_model.start_pulse();
    check("nap set", napMode, 17'h00001);
    i_sadc_host_model.sck_cycle(b, z);
    check("nap wake", napMode, 17'h00000);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    sampleValid = 1'b0;
    sampleData = '0;
    mismatches = 0;
    nTests = 0;
    repeat (8) @(posedge core_clk);
    #1 check("oe in reset", sdoOeN, 17'h00001);
    check("nap in reset", napMode, 17'h00000);
    rst_n = 1'b1;
    repeat (3) @(posedge core_clk);
    #1 check("ready after reset", sampleReady, 17'h00001);
    i_sadc_host_model.sck_cycle(b, z);
    check("oe before start", z, 17'h00001);
    fill_fifo();
    drain_frames();
    nap_check();
    end_of_test();
  end
endmodule
`default_nettype wire
